/* design/ess_cal_ref.v */
// One calibration reference register of an analog PLL, key-gated, with apply latch.
// Assumes wr_en is a one-cycle write strobe and apply a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "ess_map.vh"

module ess_cal_ref (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Write side
    input wire wr_en,
    input wire unlocked,
    input wire [7:0] wdata,
    input wire apply,
    // Register view and applied settings
    output wire [7:0] value,
    output reg [1:0] cal_level,
    output reg override_enable
);

    reg [7:0] value_reg;

    assign value = value_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_reg <= `ESS_RST_CAL_REF;
            cal_level <= 2'b00;
            override_enable <= 1'b0;
        end else begin
            if (wr_en && unlocked) begin
                value_reg <= wdata & `ESS_CAL_WMASK;
            end
            if (apply) begin
                cal_level <= value_reg[`ESS_CAL_LVL_HI:`ESS_CAL_LVL_LO];
                override_enable <= value_reg[`ESS_CAL_EN_BIT];
            end
        end
    end

endmodule
`default_nettype wire

/* design/ess_crc32.v */
// One-byte step of the reflected CRC-32.
// Assumes the caller holds the running value and feeds one byte per step.
`timescale 1ns/1ps
`default_nettype none
`include "ess_map.vh"

module ess_crc32 (
    // Running value and byte
    input wire [31:0] crc_in,
    input wire [7:0] data,
    // Updated value
    output reg [31:0] crc_out
);

    integer i;

    always @* begin
        crc_out = crc_in ^ {24'h000000, data};
        for (i = 0; i < 8; i = i + 1) begin
            if (crc_out[0]) begin
                crc_out = (crc_out >> 1) ^ `ESS_CRC_POLY;
            end else begin
                crc_out = crc_out >> 1;
            end
        end
    end

endmodule
`default_nettype wire

/* design/ess_map.vh */
// Register map, reset values and field layout of the EEPROM store sequencer.
// Assumes word-aligned APB access; indices below are register indices (byte address = 4 * index).
`ifndef ESS_MAP_VH
`define ESS_MAP_VH

// Register indices
`define ESS_IDX_SEQ_APPLY 14'h0e5e
`define ESS_IDX_SEQ_CAL 14'h0e5f
`define ESS_IDX_SEQ_SYNC 14'h0e60
`define ESS_IDX_SEQ_END 14'h0e61
`define ESS_IDX_SEQ_LAST 14'h0e6f
`define ESS_IDX_CTRL 14'h0e70
`define ESS_IDX_STATUS 14'h0e71
`define ESS_IDX_PTR 14'h0e72
`define ESS_IDX_KEY 14'h0fff
`define ESS_IDX_APPLY 14'h000f
`define ESS_IDX_CAL_BASE 14'h1488
`define ESS_IDX_CAL_MASK 14'h3cff
`define ESS_IDX_CAL_SEL_LO 8

// Reset values
`define ESS_RST_SEQ_APPLY 8'h80
`define ESS_RST_SEQ_CAL 8'h92
`define ESS_RST_SEQ_SYNC 8'ha0
`define ESS_RST_SEQ_END 8'hff
`define ESS_RST_SEQ_FREE 8'h00
`define ESS_RST_KEY 8'h00
`define ESS_RST_CAL_REF 8'h00

// Opcodes and command values
`define ESS_OP_END 8'hff
`define ESS_OP_PAUSE 8'hfe
`define ESS_KEY_UNLOCK 8'hf9
`define ESS_APPLY_CMD 8'h01

// Calibration reference fields
`define ESS_CAL_EN_BIT 0
`define ESS_CAL_LVL_LO 1
`define ESS_CAL_LVL_HI 2
`define ESS_CAL_WMASK 8'h07

// Control and status bits
`define ESS_CTRL_START_BIT 0
`define ESS_STAT_BUSY_BIT 0
`define ESS_STAT_ERR_BIT 1

// CRC-32
`define ESS_CRC_INIT 32'hffffffff
`define ESS_CRC_POLY 32'hedb88320
`define ESS_CRC_XOR 32'hffffffff
`define ESS_CRC_LAST 3'd3

`endif

/* design/ess_store.v */
// EEPROM store sequencer tail: sequence opcode bytes, CRC-32 trailer, key-gated calibration references.
// Assumes an APB master on pclk and an EEPROM byte writer that takes one byte per valid/ready handshake.
`timescale 1ns/1ps
`default_nettype none
`include "ess_map.vh"

// Operation
// - Byte 0x0E5E resets to 0x80; it is written out and the pointer advances.
// - Byte 0x0E5F resets to 0x92; it is written out and the pointer advances.
// - Byte 0x0E60 resets to 0xA0; it is written out and the pointer advances.
// - End opcode (0xFF at 0x0E61): write it, four CRC bytes, clear pointer, idle.
// - Pause opcode acts like end but the pointer keeps advancing.
// - Calibration reference registers accept writes only while key register holds 0xF9.
// - Key register resets to 0x00; any value but the key keeps access closed.
// - Bits [2:1] pick one of four reference voltages; 00b default.
// - Bit 0 enables manual override; bits [7:3] reserved, reset zero.
// - Override enable is 0 (disabled) at reset and 1 when enabled.
module ess_store #(
    parameter ADDR_W = 16,
    parameter PTR_W = 16,
    parameter SEQ_LEN = 18,
    parameter NUM_PLL = 4
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire [31:0] prdata,
    output wire pslverr,
    // EEPROM byte writer
    output wire ee_valid,
    input wire ee_ready,
    output wire [PTR_W-1:0] ee_addr,
    output wire [7:0] ee_data,
    // Sequencer status
    output wire store_busy,
    // Applied calibration reference settings, two level bits and one override enable bit per analog PLL
    output wire [2*NUM_PLL-1:0] analog_pll_cal_level,
    output wire [NUM_PLL-1:0] analog_pll_cal_override_enable
);

    // One-hot states
    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_FETCH = 5'b00010;
    localparam [4:0] ST_EMIT = 5'b00100;
    localparam [4:0] ST_CRC_LOAD = 5'b01000;
    localparam [4:0] ST_CRC_SEND = 5'b10000;

    // Whether an index falls in the sequence byte range; the slot is its offset from 0x0E5E
    function seq_hit;
        input [13:0] idx;
        begin
            seq_hit = (idx >= `ESS_IDX_SEQ_APPLY) && (idx <= `ESS_IDX_SEQ_LAST);
        end
    endfunction

    function cal_hit;
        input [13:0] idx;
        begin
            cal_hit = (idx & `ESS_IDX_CAL_MASK) == `ESS_IDX_CAL_BASE;
        end
    endfunction

    function [7:0] seq_reset;
        input integer k;
        begin
            case (k)
                0: seq_reset = `ESS_RST_SEQ_APPLY;
                1: seq_reset = `ESS_RST_SEQ_CAL;
                2: seq_reset = `ESS_RST_SEQ_SYNC;
                3: seq_reset = `ESS_RST_SEQ_END;
                default: seq_reset = `ESS_RST_SEQ_FREE;
            endcase
        end
    endfunction

    // Bus-side state
    reg [31:0] prdata_reg;
    reg [31:0] prdata_next;
    reg pslverr_reg;
    reg [7:0] key_reg;
    reg [7:0] seq_mem [0:SEQ_LEN-1];

    // Sequencer state
    reg [4:0] state_reg;
    reg [4:0] slot_reg;
    reg [PTR_W-1:0] ptr_reg;
    reg [31:0] crc_reg;
    reg [2:0] crc_cnt_reg;
    reg term_reg;
    reg pause_reg;
    reg err_reg;
    reg [7:0] ee_data_reg;
    reg [PTR_W-1:0] ee_addr_reg;

    // Address decode
    wire [13:0] reg_idx;
    wire [13:0] seq_off;
    wire aligned;
    wire mapped;
    wire wr_ok;
    wire busy;
    wire unlocked;
    wire apply_pulse;
    wire start_pulse;
    wire [1:0] cal_sel;
    wire [8*NUM_PLL-1:0] cal_value;
    wire [31:0] crc_upd;
    wire [31:0] crc_final;
    wire [7:0] cur_byte;
    // Register selects
    wire sel_seq;
    wire sel_cal;
    wire sel_key;
    wire sel_apply;
    wire sel_ctrl;
    wire sel_status;
    wire sel_ptr;
    // Sequencer decodes
    wire st_idle;
    wire st_emit;
    wire st_send;
    wire byte_taken;
    wire cur_term;
    wire cur_pause;
    wire [7:0] crc_byte;

    assign reg_idx = paddr[15:2];
    assign seq_off = reg_idx - `ESS_IDX_SEQ_APPLY;
    assign aligned = (paddr[1:0] == 2'b00);
    assign cal_sel = reg_idx[`ESS_IDX_CAL_SEL_LO+1:`ESS_IDX_CAL_SEL_LO];

    // State decodes
    assign st_idle = state_reg[0];
    assign st_emit = state_reg[2];
    assign st_send = state_reg[4];
    assign byte_taken = ee_valid && ee_ready;
    assign busy = ~st_idle;
    // only the exact key opens access
    assign unlocked = (key_reg == `ESS_KEY_UNLOCK);

    // One select per register, shared by the map check, the read mux and the writes
    assign sel_seq = seq_hit(reg_idx);
    assign sel_cal = cal_hit(reg_idx);
    assign sel_key = (reg_idx == `ESS_IDX_KEY);
    assign sel_apply = (reg_idx == `ESS_IDX_APPLY);
    assign sel_ctrl = (reg_idx == `ESS_IDX_CTRL);
    assign sel_status = (reg_idx == `ESS_IDX_STATUS);
    assign sel_ptr = (reg_idx == `ESS_IDX_PTR);

    // Address map check; anything else answers with an error
    assign mapped = aligned && (sel_seq || sel_cal || sel_key || sel_apply ||
        sel_ctrl || sel_status || sel_ptr);

    // Zero wait states; read data and error are captured in the setup cycle
    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign wr_ok = psel && penable && pwrite && mapped;

    // Apply copies every reference at once, whatever the key holds
    assign apply_pulse = wr_ok && sel_apply && (pwdata[7:0] == `ESS_APPLY_CMD);
    // A start while busy is dropped by the idle state
    assign start_pulse = wr_ok && sel_ctrl && pwdata[`ESS_CTRL_START_BIT];

    // Read mux
    always @* begin
        prdata_next = 32'h00000000;
        // Control and apply words fall through and read zero
        if (sel_seq) begin
            prdata_next[7:0] = seq_mem[seq_off[4:0]];
        end else if (sel_cal) begin
            prdata_next[7:0] = cal_value[cal_sel*8 +: 8];
        end else if (sel_key) begin
            prdata_next[7:0] = key_reg;
        end else if (sel_status) begin
            prdata_next[`ESS_STAT_BUSY_BIT] = busy;
            prdata_next[`ESS_STAT_ERR_BIT] = err_reg;
        end else if (sel_ptr) begin
            prdata_next[PTR_W-1:0] = ptr_reg;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (psel && !penable) begin
            prdata_reg <= pwrite ? 32'h00000000 : prdata_next;
            pslverr_reg <= ~mapped;
        end
    end

    // Key register and sequence bytes
    integer k;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_reg <= `ESS_RST_KEY;
            for (k = 0; k < SEQ_LEN; k = k + 1) begin
                seq_mem[k] <= seq_reset(k);
            end
        end else begin
            if (wr_ok && sel_key) begin
                key_reg <= pwdata[7:0];
            end
            // Sequence bytes are frozen while a store runs, so the CRC matches what was sent
            if (wr_ok && sel_seq && !busy) begin
                seq_mem[seq_off[4:0]] <= pwdata[7:0];
            end
        end
    end

    // Calibration reference registers, one per analog PLL
    genvar g;
    generate
        for (g = 0; g < NUM_PLL; g = g + 1) begin : g_cal
            ess_cal_ref u_cal_ref (
                .pclk(pclk),
                .presetn(presetn),
                .wr_en(wr_ok && sel_cal && cal_sel == g),
                .unlocked(unlocked),
                .wdata(pwdata[7:0]),
                .apply(apply_pulse),
                .value(cal_value[8*g +: 8]),
                .cal_level(analog_pll_cal_level[2*g +: 2]),
                .override_enable(analog_pll_cal_override_enable[g])
            );
        end
    endgenerate

    // CRC over every byte of the current profile
    ess_crc32 u_crc (
        .crc_in(crc_reg),
        .data(ee_data_reg),
        .crc_out(crc_upd)
    );

    // Running value is kept without the final xor; only the trailer bytes carry it
    assign crc_final = crc_reg ^ `ESS_CRC_XOR;
    assign crc_byte = crc_final[crc_cnt_reg*8 +: 8];
    assign cur_byte = seq_mem[slot_reg];

    // End and pause both close a profile with the CRC trailer
    assign cur_pause = (cur_byte == `ESS_OP_PAUSE);
    assign cur_term = (cur_byte == `ESS_OP_END) || cur_pause;

    // A byte is offered only in the two send states
    assign ee_valid = st_emit | st_send;
    assign ee_addr = ee_addr_reg;
    assign ee_data = ee_data_reg;
    assign store_busy = busy;

    // Store sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            slot_reg <= 5'd0;
            ptr_reg <= {PTR_W{1'b0}};
            crc_reg <= `ESS_CRC_INIT;
            crc_cnt_reg <= 3'd0;
            term_reg <= 1'b0;
            pause_reg <= 1'b0;
            err_reg <= 1'b0;
            ee_data_reg <= 8'h00;
            ee_addr_reg <= {PTR_W{1'b0}};
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_pulse) begin
                        slot_reg <= 5'd0;
                        crc_reg <= `ESS_CRC_INIT;
                        // A fresh start clears the error of the last run
                        err_reg <= 1'b0;
                        state_reg <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    // Latch the byte and its address before offering it
                    ee_data_reg <= cur_byte;
                    ee_addr_reg <= ptr_reg;
                    term_reg <= cur_term;
                    pause_reg <= cur_pause;
                    state_reg <= ST_EMIT;
                end
                ST_EMIT: begin
                    // Pointer and CRC move only when the byte is really taken
                    if (byte_taken) begin
                        ptr_reg <= ptr_reg + 1'b1;
                        crc_reg <= crc_upd;
                        if (term_reg) begin
                            crc_cnt_reg <= 3'd0;
                            state_reg <= ST_CRC_LOAD;
                        end else if (slot_reg == SEQ_LEN - 1) begin
                            // Ran off the end without a terminator
                            err_reg <= 1'b1;
                            state_reg <= ST_IDLE;
                        end else begin
                            slot_reg <= slot_reg + 1'b1;
                            state_reg <= ST_FETCH;
                        end
                    end
                end
                ST_CRC_LOAD: begin
                    ee_data_reg <= crc_byte;
                    ee_addr_reg <= ptr_reg;
                    state_reg <= ST_CRC_SEND;
                end
                ST_CRC_SEND: begin
                    if (byte_taken) begin
                        if (crc_cnt_reg == `ESS_CRC_LAST) begin
                            // end clears pointer; pause advances it past the last CRC byte
                            ptr_reg <= pause_reg ? ptr_reg + 1'b1 : {PTR_W{1'b0}};
                            state_reg <= ST_IDLE;
                        end else begin
                            ptr_reg <= ptr_reg + 1'b1;
                            crc_cnt_reg <= crc_cnt_reg + 1'b1;
                            state_reg <= ST_CRC_LOAD;
                        end
                    end
                end
                default: begin
                    // Illegal codes fall back to idle
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

/* verif/ess_eeprom_model.sv */
// EEPROM byte sink on the far side of the store sequencer.
// Assumes the bench drives hold with random stalls after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module ess_eeprom_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Byte port
    input wire logic ee_valid,
    input wire logic [15:0] ee_addr,
    input wire logic [7:0] ee_data,
    output logic ee_ready,
    // Stall request
    input wire logic hold
);
    logic [7:0] mem [0:255];
    int taken;
    assign ee_ready = !hold;
    // Store each accepted byte at its pointer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taken <= 0;
        end else if (ee_valid && ee_ready) begin
            mem[ee_addr[7:0]] <= ee_data;
            taken <= taken + 1;
        end
    end
endmodule
`default_nettype wire

/* verif/ess_store_monitor.sv */
// Port checker for the EEPROM store sequencer.
// Assumes a bind onto ess_store, one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "ess_map.vh"
module ess_store_monitor #(
    parameter ADDR_W = 16,
    parameter PTR_W = 16,
    parameter NUM_PLL = 4
) (
    // Clock, reset and APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    // EEPROM side and status
    input wire logic ee_valid,
    input wire logic ee_ready,
    input wire logic [PTR_W-1:0] ee_addr,
    input wire logic [7:0] ee_data,
    input wire logic store_busy,
    // Applied settings
    input wire logic [2*NUM_PLL-1:0] analog_pll_cal_level,
    input wire logic [NUM_PLL-1:0] analog_pll_cal_override_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic wr_acc = psel && penable && pwrite;
    wire logic take = ee_valid && ee_ready;

    property p_start_fetch;
        wr_acc && paddr == {`ESS_IDX_CTRL, 2'b00} && pwdata[0] && !store_busy |=> store_busy && !ee_valid ##1 ee_valid;
    endproperty
    a_start_fetch: assert property (p_start_fetch) else $error("start not followed by fetch and offer");
    property p_hold_offer;
        ee_valid && !ee_ready |=> ee_valid && $stable(ee_data) && $stable(ee_addr);
    endproperty
    a_hold_offer: assert property (p_hold_offer) else $error("offered byte changed before taken");
    property p_fetch_gap;
        take |=> !ee_valid;
    endproperty
    a_fetch_gap: assert property (p_fetch_gap) else $error("no gap after a taken byte");
    property p_ptr_step;
        take ##2 ee_valid |-> ee_addr == $past(ee_addr, 2) + 1'b1;
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("pointer did not advance by one");
    property p_offer_busy;
        ee_valid |-> store_busy;
    endproperty
    a_offer_busy: assert property (p_offer_busy) else $error("byte offered while idle");
    property p_reset_quiet;
        $rose(presetn) |-> !ee_valid && !store_busy && analog_pll_cal_level == '0 && analog_pll_cal_override_enable == '0;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared by reset");
    property p_apply_only;
        $changed(analog_pll_cal_level) || $changed(analog_pll_cal_override_enable)
            |-> $past(wr_acc && paddr == {`ESS_IDX_APPLY, 2'b00} && pwdata[7:0] == 8'h01);
    endproperty
    a_apply_only: assert property (p_apply_only) else $error("applied settings moved without apply");
    property p_idle_after_take;
        $fell(store_busy) |-> $past(take);
    endproperty
    a_idle_after_take: assert property (p_idle_after_take) else $error("went idle without a final byte");
endmodule
`default_nettype wire

/* verif/ess_store_tb.sv */
// Self-checking bench for the EEPROM store sequencer.
// Assumes the design, EEPROM model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ess_map.vh"
module ess_store_tb;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [15:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic hold = 0;
    wire pready, pslverr, ee_valid, ee_ready, store_busy;
    wire [31:0] prdata;
    wire [15:0] ee_addr;
    wire [7:0] ee_data, cal_lvl;
    wire [3:0] cal_en;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    integer seed = 10;
    int seq_m [0:17];
    int ptr_m = 0;
    logic [31:0] rd;
    logic err;
    logic [7:0] key;

    ess_store i_ess_store (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .ee_valid(ee_valid),
        .ee_ready(ee_ready), .ee_addr(ee_addr), .ee_data(ee_data), .store_busy(store_busy),
        .analog_pll_cal_level(cal_lvl), .analog_pll_cal_override_enable(cal_en));
    ess_eeprom_model i_ess_eeprom_model (.pclk(pclk), .presetn(presetn), .ee_valid(ee_valid), .ee_addr(ee_addr),
        .ee_data(ee_data), .ee_ready(ee_ready), .hold(hold));

    always #50 pclk = ~pclk;
    always @(posedge pclk) begin
        hold <= ($random(seed) & 3) == 0;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] wd, input logic [1:0] lo);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, lo};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [13:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 2'b00);
    endtask
    task automatic rdc(input string what, input logic [13:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00, 2'b00);
        chk(what, {24'h0, exp}, rd);
        chk("pslverr", 32'h0, {31'h0, err});
    endtask
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
        c = c ^ {24'h0, b};
        for (int k = 0; k < 8; k++)
            c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
        return c;
    endfunction
    // Runs one store with random stalls and compares every byte written
    task automatic run_store();
        logic [31:0] crc;
        int n, base, t0, w;
        logic term;
        crc = 32'hffffffff;
        term = 1'b0;
        n = 0;
        w = 0;
        base = ptr_m;
        t0 = i_ess_eeprom_model.taken;
        wr(`ESS_IDX_CTRL, 8'h01);
        wr(`ESS_IDX_SEQ_APPLY, 8'h55);
        rdc("status busy", `ESS_IDX_STATUS, 8'h01);
        while (store_busy === 1'b1) begin
            @(posedge pclk);
            w++;
        end
        for (int i = 0; i < 18; i++) begin
            chk("ee opcode", seq_m[i], i_ess_eeprom_model.mem[(base + n) & 255]);
            crc = crc_step(crc, seq_m[i][7:0]);
            n++;
            if (seq_m[i] >= 'hfe) begin
                term = 1'b1;
                break;
            end
        end
        crc = ~crc;
        for (int k = 0; k < 4 && term; k++) begin
            chk("ee crc", crc[8*k+:8], i_ess_eeprom_model.mem[(base + n) & 255]);
            n++;
        end
        chk("ee count", n, i_ess_eeprom_model.taken - t0);
        ptr_m = (seq_m[3] == 'hff) ? 0 : base + n;
        rdc("pointer", `ESS_IDX_PTR, 8'(ptr_m));
        rdc("status", `ESS_IDX_STATUS, term ? 8'h00 : 8'h02);
        rdc("slot 0", `ESS_IDX_SEQ_APPLY, 8'h80);
    endtask

    initial begin
        seq_m = '{default: 0};
        seq_m[0] = 'h80;
        seq_m[1] = 'h92;
        seq_m[2] = 'ha0;
        seq_m[3] = 'hff;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 18; i++)
            rdc("seq slot", 14'(`ESS_IDX_SEQ_APPLY + i), 8'(seq_m[i]));
        rdc("key", `ESS_IDX_KEY, 8'h00);
        for (int p = 0; p < 4; p++)
            rdc("cal ref", 14'(`ESS_IDX_CAL_BASE + p * 'h100), 8'h00);
        key = 8'($random(seed));
        if (key == 8'hf9)
            key = 8'h00;
        wr(`ESS_IDX_KEY, key);
        rdc("key", `ESS_IDX_KEY, key);
        wr(`ESS_IDX_CAL_BASE, 8'hff);
        rdc("locked cal", `ESS_IDX_CAL_BASE, 8'h00);
        wr(`ESS_IDX_KEY, 8'hf9);
        for (int p = 0; p < 4; p++)
            wr(14'(`ESS_IDX_CAL_BASE + p * 'h100), 8'(8'hf8 | (p << 1) | (p & 1)));
        for (int p = 0; p < 4; p++)
            rdc("cal ref", 14'(`ESS_IDX_CAL_BASE + p * 'h100), 8'((p << 1) | (p & 1)));
        chk("level early", 32'h0, {24'h0, cal_lvl});
        wr(`ESS_IDX_APPLY, 8'h01);
        @(posedge pclk);
        #1;
        chk("levels", 32'he4, {24'h0, cal_lvl});
        chk("enables", 32'ha, {28'h0, cal_en});
        wr(`ESS_IDX_KEY, 8'h00);
        wr(14'(`ESS_IDX_CAL_BASE + 'h300), 8'h00);
        rdc("relocked cal", 14'(`ESS_IDX_CAL_BASE + 'h300), 8'h07);
        apb(1'b0, 14'h0100, 8'h00, 2'b00);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b1, `ESS_IDX_KEY, 8'hf9, 2'b10);
        chk("misaligned err", 32'h1, {31'h0, err});
        rdc("key", `ESS_IDX_KEY, 8'h00);
        run_store();
        seq_m[3] = 'h80 + ($random(seed) & 'h7f) % 'h7e;
        seq_m[4] = 'hfe;
        wr(`ESS_IDX_SEQ_END, 8'(seq_m[3]));
        wr(14'(`ESS_IDX_SEQ_END + 1), 8'hfe);
        repeat (2) run_store();
        seq_m[3] = 'hff;
        wr(`ESS_IDX_SEQ_END, 8'hff);
        run_store();
        seq_m[3] = 'h7f;
        seq_m[4] = 'h00;
        wr(`ESS_IDX_SEQ_END, 8'h7f);
        wr(14'(`ESS_IDX_SEQ_END + 1), 8'h00);
        run_store();
        conclude();
    end
endmodule
bind ess_store ess_store_monitor #(.ADDR_W(ADDR_W), .PTR_W(PTR_W), .NUM_PLL(NUM_PLL)) i_ess_store_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .ee_valid(ee_valid), .ee_ready(ee_ready), .ee_addr(ee_addr), .ee_data(ee_data),
    .store_busy(store_busy), .analog_pll_cal_level(analog_pll_cal_level),
    .analog_pll_cal_override_enable(analog_pll_cal_override_enable));
`default_nettype wire
